// ---- sar_adc_sequencer.sv ----
/*
 Control logic of an eight-channel successive-approximation converter:
 register port, start selection, channel sequencing, data protection and
 completion interrupt. Assumes one 50 MHz clock; trigger and comparator
 pins arrive asynchronously.
*/
// Overview of operation
// - Software picks an 8-bit or a 10-bit result.
// - Software picks one of eight analog channels.
// - Each value is found by one comparator decision per step after sampling.
// - A start comes from software, reload timer rising edge or free-run zero edge.
// - Completion raises an interrupt that may call the transfer service.
// - With the interrupt enabled, an uncollected result is not overwritten.
// - Single-shot on one channel converts once and stops.
// - Single-shot scan converts each channel of the range once, then stops.
// - Continuous on one channel repeats without a new start.
// - Continuous scan cycles through the range repeatedly.
// - The sampling phase lasts at least 2.0 us.
// - A whole conversion takes at least 6.13 us.
`timescale 1ns/10ps
`default_nettype none
module sar_adc_sequencer
#(
   parameter int NUM_CH = 8
)
(
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic [3:0]  addr,
   input  wire logic [15:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic [15:0]      rdata,
   input  wire logic        reload_out,
   input  wire logic        freerun_zero,
   input  wire logic        cmp_hi,
   output logic [2:0]       ch_sel,
   output logic             sample_hold,
   output logic [9:0]       dac_code,
   output logic             irq,
   output logic             xfer_req,
   output logic             busy
);
   // ==========================================================
   // Pin synchronisers: three flops, change when last two agree
   logic [2:0] rl_s_r, fz_s_r, cp_s_r;
   logic       rl_r, fz_r, cp_r, rl_q_r, fz_q_r;

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rl_s_r <= 3'h0;
         fz_s_r <= 3'h0;
         cp_s_r <= 3'h0;
         rl_r   <= 1'b0;
         fz_r   <= 1'b0;
         cp_r   <= 1'b0;
         rl_q_r <= 1'b0;
         fz_q_r <= 1'b0;
      end
      else
      begin
         rl_s_r <= {rl_s_r[1:0], reload_out};
         fz_s_r <= {fz_s_r[1:0], freerun_zero};
         cp_s_r <= {cp_s_r[1:0], cmp_hi};
         if (rl_s_r[1] == rl_s_r[2])
            rl_r <= rl_s_r[2];
         if (fz_s_r[1] == fz_s_r[2])
            fz_r <= fz_s_r[2];
         if (cp_s_r[1] == cp_s_r[2])
            cp_r <= cp_s_r[2];
         rl_q_r <= rl_r;
         fz_q_r <= fz_r;
      end
   end

   // ==========================================================
   // Registers
   adc_seq_pkg::adc_cfg_t cfg_r;
   logic [2:0]  ch_lo_r, ch_hi_r, cur_r;
   logic [1:0]  ist_r, imk_r;
   logic [9:0]  data_r;
   logic        unread_r;
   logic        sw_start, sw_stop, core_done, go_r, core_samp;
   logic [9:0]  core_res, core_trial;

   function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
      return a == o;
   endfunction

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cfg_r   <= adc_seq_pkg::adc_cfg_t'(adc_seq_pkg::CTRL_RESET[6:0]);
         ch_lo_r <= 3'h0;
         ch_hi_r <= 3'h0;
         imk_r   <= 2'h0;
      end
      else if (wr && hit(addr, adc_seq_pkg::OFF_CTRL))
      begin
         cfg_r.mode <= adc_seq_pkg::conv_mode_t'(
            wdata[adc_seq_pkg::CTRL_MODE_HI:adc_seq_pkg::CTRL_MODE_LO]);
         cfg_r.src  <= adc_seq_pkg::start_src_t'(
            wdata[adc_seq_pkg::CTRL_SRC_HI:adc_seq_pkg::CTRL_SRC_LO]);
         cfg_r.res8 <= wdata[adc_seq_pkg::CTRL_RES8];
         cfg_r.scan <= wdata[adc_seq_pkg::CTRL_SCAN];
         cfg_r.xfer <= wdata[adc_seq_pkg::CTRL_XFER];
      end
      else if (wr && hit(addr, adc_seq_pkg::OFF_RANGE))
      begin
         ch_lo_r <= wdata[2:0];
         ch_hi_r <= wdata[adc_seq_pkg::RANGE_END_LO +: 3];
      end
      else if (wr && hit(addr, adc_seq_pkg::OFF_IRQ_MK))
         imk_r <= wdata[1:0];
   end

   assign sw_start = wr && hit(addr, adc_seq_pkg::OFF_CMD)
                     && wdata[adc_seq_pkg::CMD_START];
   assign sw_stop  = wr && hit(addr, adc_seq_pkg::OFF_CMD)
                     && wdata[adc_seq_pkg::CTRL_STOP];

   // ==========================================================
   // Start selection
   logic trig;
   always_comb
   begin
      case (cfg_r.src)
         adc_seq_pkg::SRC_SOFT:    trig = sw_start;
         adc_seq_pkg::SRC_RELOAD:  trig = rl_r && !rl_q_r;
         adc_seq_pkg::SRC_FREERUN: trig = fz_r && !fz_q_r;
         default:                  trig = 1'b0;
      endcase
   end

   // ==========================================================
   // Channel sequencing
   typedef enum logic [1:0] {Q_IDLE, Q_CONV, Q_WAIT} seq_st_t;
   seq_st_t seq_r;
   logic    last_ch;
   logic    single_mode;
   logic    incr_resume;
   // A stop waits for the running conversion, so a later start never
   // meets a core that is still busy
   logic    stop_r;

   assign last_ch     = !cfg_r.scan || (cur_r == ch_hi_r);
   assign single_mode = (cfg_r.mode == adc_seq_pkg::MODE_SINGLE1) ||
                        (cfg_r.mode == adc_seq_pkg::MODE_SINGLE2);
   assign incr_resume = (seq_r == Q_WAIT) && trig;

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         seq_r <= Q_IDLE;
         cur_r <= 3'h0;
         go_r  <= 1'b0;
         busy  <= 1'b0;
         stop_r <= 1'b0;
      end
      else
      begin
         go_r <= 1'b0;
         case (seq_r)
            Q_IDLE:
               if (trig)
               begin
                  stop_r <= 1'b0;
                  seq_r <= Q_CONV;
                  cur_r <= ch_lo_r;
                  go_r  <= 1'b1;
                  busy  <= 1'b1;
               end
            Q_CONV:
               if (core_done && (sw_stop || stop_r))
               begin
                  seq_r  <= Q_IDLE;
                  busy   <= 1'b0;
                  stop_r <= 1'b0;
               end
               else if (sw_stop)
                  stop_r <= 1'b1;
               else if (core_done)
               begin
                  if (!last_ch)
                  begin
                     cur_r <= cur_r + 3'h1;
                     go_r  <= (cfg_r.mode != adc_seq_pkg::MODE_INCR);
                     if (cfg_r.mode == adc_seq_pkg::MODE_INCR)
                     begin
                        seq_r <= Q_WAIT;
                        busy  <= 1'b0;
                     end
                  end
                  else if (cfg_r.mode == adc_seq_pkg::MODE_CONT)
                  begin
                     cur_r <= ch_lo_r;
                     go_r  <= 1'b1;
                  end
                  else
                  begin
                     seq_r <= Q_IDLE;
                     busy  <= 1'b0;
                  end
               end
            Q_WAIT:
               if (sw_stop)
               begin
                  seq_r <= Q_IDLE;
                  busy  <= 1'b0;
               end
               else if (incr_resume)
               begin
                  seq_r <= Q_CONV;
                  go_r  <= 1'b1;
                  busy  <= 1'b1;
               end
            default: seq_r <= Q_IDLE;
         endcase
      end
   end

   adc_sar_core u_core
   (
      .clk     (clk),
      .reset_n (reset_n),
      .go      (go_r),
      .res8    (cfg_r.res8),
      .cmp_hi  (cp_r),
      .sample  (core_samp),
      .trial   (core_trial),
      .done    (core_done),
      .result  (core_res)
   );

   // ==========================================================
   // Result, protection and interrupt
   logic irq_en, rd_result, store;
   assign irq_en    = imk_r[adc_seq_pkg::IRQ_DONE];
   assign rd_result = rd && hit(addr, adc_seq_pkg::OFF_RESULT);
   // Protected result held until collected while interrupt is enabled
   assign store     = core_done && !(irq_en && unread_r);

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         data_r   <= 10'h000;
         unread_r <= 1'b0;
      end
      else
      begin
         if (store)
            data_r <= core_res;
         if (store)
            unread_r <= 1'b1;
         else if (rd_result)
            unread_r <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         ist_r <= 2'h0;
      else
      begin
         // Set wins over a write-one clear
         ist_r[adc_seq_pkg::IRQ_DONE] <= core_done ||
            (ist_r[adc_seq_pkg::IRQ_DONE] &&
             !(wr && hit(addr, adc_seq_pkg::OFF_IRQ_ST) &&
               wdata[adc_seq_pkg::IRQ_DONE]));
         ist_r[adc_seq_pkg::IRQ_OVERRUN] <= (core_done && !store) ||
            (ist_r[adc_seq_pkg::IRQ_OVERRUN] &&
             !(wr && hit(addr, adc_seq_pkg::OFF_IRQ_ST) &&
               wdata[adc_seq_pkg::IRQ_OVERRUN]));
      end
   end

   // ==========================================================
   // Outputs and read port
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         irq         <= 1'b0;
         xfer_req    <= 1'b0;
         ch_sel      <= 3'h0;
         sample_hold <= 1'b0;
         dac_code    <= 10'h000;
         rdata       <= 16'h0000;
      end
      else
      begin
         irq      <= |(ist_r & imk_r) && !cfg_r.xfer;
         xfer_req <= |(ist_r & imk_r) && cfg_r.xfer;
         ch_sel      <= cur_r;
         sample_hold <= core_samp;
         dac_code    <= core_trial;
         rdata       <= 16'h0000;
         if (rd)
            case (addr)
               adc_seq_pkg::OFF_CTRL:
                  rdata <= {9'h000, cfg_r.xfer, cfg_r.scan, cfg_r.res8,
                            cfg_r.src, cfg_r.mode};
               adc_seq_pkg::OFF_RANGE:
                  rdata <= {9'h000, ch_hi_r, 1'b0, ch_lo_r};
               adc_seq_pkg::OFF_STATUS:
                  rdata <= {13'h0000, unread_r, seq_r == Q_WAIT, busy};
               adc_seq_pkg::OFF_RESULT: rdata <= {6'h00, data_r};
               adc_seq_pkg::OFF_IRQ_ST: rdata <= {14'h0000, ist_r};
               adc_seq_pkg::OFF_IRQ_MK: rdata <= {14'h0000, imk_r};
               adc_seq_pkg::OFF_CHAN:   rdata <= {13'h0000, cur_r};
               default:                 rdata <= 16'h0000;
            endcase
      end
   end

   // ==========================================================
   // Checks
   int unsigned conv_cnt;
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         conv_cnt <= 0;
      else if (go_r)
         conv_cnt <= 0;
      else
         conv_cnt <= conv_cnt + 1;
   end

   property p_conv_time;
      @(posedge clk) disable iff (!reset_n)
      core_done |-> conv_cnt + 1 >= adc_seq_pkg::CONV_CYC;
   endproperty
   a_conv_time: assert property (p_conv_time)
      else $error("conversion shorter than minimum");

   property p_sample_len;
      @(posedge clk) disable iff (!reset_n)
      $rose(core_samp) |-> core_samp [*8];
   endproperty
   a_sample_len: assert property (p_sample_len)
      else $error("sample phase too short");

   property p_protect;
      @(posedge clk) disable iff (!reset_n)
      (core_done && irq_en && unread_r) |=> $stable(data_r);
   endproperty
   a_protect: assert property (p_protect)
      else $error("protected result overwritten");

   property p_busy_start;
      @(posedge clk) disable iff (!reset_n)
      (seq_r == Q_IDLE && trig) |=> busy && go_r;
   endproperty
   a_busy_start: assert property (p_busy_start)
      else $error("start not taken");

   property p_single_stop;
      @(posedge clk) disable iff (!reset_n)
      (core_done && single_mode && last_ch && seq_r == Q_CONV)
         |=> !busy && !go_r;
   endproperty
   a_single_stop: assert property (p_single_stop)
      else $error("single shot did not stop");

   property p_cont_restart;
      @(posedge clk) disable iff (!reset_n)
      (core_done && seq_r == Q_CONV && !sw_stop && !stop_r &&
       cfg_r.mode == adc_seq_pkg::MODE_CONT) |=> go_r && busy;
   endproperty
   a_cont_restart: assert property (p_cont_restart)
      else $error("continuous mode did not restart");

   property p_scan_step;
      @(posedge clk) disable iff (!reset_n)
      (core_done && seq_r == Q_CONV && !sw_stop && !stop_r && !last_ch)
         |=> cur_r == $past(cur_r) + 3'h1;
   endproperty
   a_scan_step: assert property (p_scan_step)
      else $error("scan did not advance");

   property p_incr_wait;
      @(posedge clk) disable iff (!reset_n)
      (core_done && seq_r == Q_CONV && !sw_stop && !stop_r && !last_ch &&
       cfg_r.mode == adc_seq_pkg::MODE_INCR)
         |=> seq_r == Q_WAIT && !go_r && !busy;
   endproperty
   a_incr_wait: assert property (p_incr_wait)
      else $error("incremental mode did not wait");

   property p_res8;
      @(posedge clk) disable iff (!reset_n)
      (store && cfg_r.res8) |=> data_r[9:8] == 2'b00;
   endproperty
   a_res8: assert property (p_res8)
      else $error("upper bits set in 8-bit mode");
endmodule // sar_adc_sequencer
`default_nettype wire

// ---- adc_seq_pkg.sv ----
/*
 Package for the successive-approximation converter sequencer: register
 offsets, field positions, reset values, modes, start sources and timing.
 Assumes a single 50 MHz clock domain.
*/
package adc_seq_pkg;
   // ==========================================================
   // Register offsets (word index on the plain register port)
   localparam logic [3:0] OFF_CTRL   = 4'h0;
   localparam logic [3:0] OFF_RANGE  = 4'h1;
   localparam logic [3:0] OFF_STATUS = 4'h2;
   localparam logic [3:0] OFF_RESULT = 4'h3;
   localparam logic [3:0] OFF_IRQ_ST = 4'h4;
   localparam logic [3:0] OFF_IRQ_MK = 4'h5;
   localparam logic [3:0] OFF_CMD    = 4'h6;
   localparam logic [3:0] OFF_CHAN   = 4'h7;

   // ==========================================================
   // Control, command, range and interrupt register layout
   localparam int CTRL_MODE_LO  = 0;
   localparam int CTRL_MODE_HI  = 1;
   localparam int CTRL_SRC_LO   = 2;
   localparam int CTRL_SRC_HI   = 3;
   localparam int CTRL_RES8     = 4;
   localparam int CTRL_SCAN     = 5;
   localparam int CTRL_XFER     = 6;
   localparam int CTRL_STOP     = 7;
   localparam int CMD_START     = 0;
   localparam int RANGE_END_LO  = 4;
   localparam int IRQ_DONE      = 0;
   localparam int IRQ_OVERRUN   = 1;
   localparam logic [7:0] CTRL_RESET = 8'h00;

   typedef enum logic [1:0] {
      MODE_SINGLE1, MODE_SINGLE2, MODE_CONT, MODE_INCR
   } conv_mode_t;

   typedef enum logic [1:0] {
      SRC_SOFT, SRC_RELOAD, SRC_FREERUN, SRC_NONE
   } start_src_t;

   typedef struct packed {
      conv_mode_t mode;
      start_src_t src;
      logic       res8;
      logic       scan;
      logic       xfer;
   } adc_cfg_t;

   // ==========================================================
   // Timing
   localparam int CLK_MHZ       = 50;
   localparam int SAMPLE_NS     = 2000;
   localparam int CONV_NS       = 6130;
   localparam int SAMPLE_CYC    = (SAMPLE_NS * CLK_MHZ + 999) / 1000;
   localparam int CONV_CYC      = (CONV_NS * CLK_MHZ + 999) / 1000;
   localparam int RES_BITS      = 10;
   localparam int RES_BITS8     = 8;
   localparam int STEP_CYC      = (CONV_CYC - SAMPLE_CYC + RES_BITS - 1)
                                  / RES_BITS;
endpackage

// ---- adc_sar_core.sv ----
/*
 Successive-approximation core: holds the sample phase, then makes one
 bit decision per step from the comparator. Assumes the comparator input
 is synchronised by the caller.
*/
`timescale 1ns/10ps
`default_nettype none
module adc_sar_core
#(
   parameter int SAMPLE_CYC = adc_seq_pkg::SAMPLE_CYC,
   parameter int STEP_CYC   = adc_seq_pkg::STEP_CYC
)
(
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic       go,
   input  wire logic       res8,
   input  wire logic       cmp_hi,
   output logic            sample,
   output logic [9:0]      trial,
   output logic            done,
   output logic [9:0]      result
);
   // ==========================================================
   // Sequencer
   typedef enum logic [1:0] {S_IDLE, S_SAMP, S_BITS} core_st_t;
   core_st_t    st_r;
   logic [7:0]  cnt_r;
   logic [3:0]  bit_r;
   logic [9:0]  acc_r;
   // Fewer decisions in 8-bit mode, so each step is longer to keep the
   // whole conversion above its minimum
   localparam int STEP8_CYC = (adc_seq_pkg::CONV_CYC - SAMPLE_CYC
                               + adc_seq_pkg::RES_BITS8 - 1)
                              / adc_seq_pkg::RES_BITS8;

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         st_r   <= S_IDLE;
         cnt_r  <= 8'h00;
         bit_r  <= 4'h0;
         acc_r  <= 10'h000;
         done   <= 1'b0;
         result <= 10'h000;
      end
      else
      begin
         done <= 1'b0;
         case (st_r)
            S_IDLE:
               if (go)
               begin
                  st_r  <= S_SAMP;
                  cnt_r <= 8'(SAMPLE_CYC - 1);
                  acc_r <= 10'h000;
               end
            S_SAMP:
               // Sample phase at least the documented minimum
               if (cnt_r == 8'h00)
               begin
                  st_r  <= S_BITS;
                  cnt_r <= res8 ? 8'(STEP8_CYC - 1) : 8'(STEP_CYC - 1);
                  bit_r <= 4'(adc_seq_pkg::RES_BITS - 1);
               end
               else
                  cnt_r <= cnt_r - 8'h01;
            S_BITS:
               if (cnt_r == 8'h00)
               begin
                  // One decision per step, MSB first
                  acc_r[bit_r] <= cmp_hi;
                  cnt_r <= res8 ? 8'(STEP8_CYC - 1) : 8'(STEP_CYC - 1);
                  if (bit_r == 4'h0 || (res8 && bit_r == 4'h2))
                  begin
                     st_r   <= S_IDLE;
                     done   <= 1'b1;
                     // 8-bit result sits low, upper bits zero
                     result <= res8 ? {2'b00, acc_r[9:3], cmp_hi}
                                    : {acc_r[9:1], cmp_hi};
                  end
                  else
                     bit_r <= bit_r - 4'h1;
               end
               else
                  cnt_r <= cnt_r - 8'h01;
            default: st_r <= S_IDLE;
         endcase
      end
   end

   always_comb
   begin
      sample = (st_r == S_SAMP);
      trial  = acc_r;
      if (st_r == S_BITS)
         trial[bit_r] = 1'b1;
   end
endmodule // adc_sar_core
`default_nettype wire

// ---- adc_front_model.sv ----
/*
 Behavioural model of the analog input multiplexer and the sample-and-hold
 comparator that sit on the far side of the converter sequencer.
 Assumes the bench supplies one analog level per channel in code units.
*/
`timescale 1ns/10ps
`default_nettype none
module adc_front_model
(
   input  wire logic       clk,
   input  wire logic [2:0] ch_sel,
   input  wire logic       sample_hold,
   input  wire logic [9:0] dac_code,
   input  wire logic [9:0] level [8],
   output logic            cmp_hi
);
   // ==========================================================
   // Hold stage and comparator
   logic [9:0] held_r = 10'h000;
   logic       tog_r  = 1'b0;

   always @(posedge clk)
   begin
      tog_r <= ~tog_r;
      if (sample_hold)
         held_r <= level[ch_sel];
   end

   // Level sits half a code above held_r, so an equal trial reads high;
   // while tracking, the comparator output is meaningless and toggles
   assign cmp_hi = sample_hold ? tog_r : (held_r >= dac_code);
endmodule // adc_front_model
`default_nettype wire

// ---- tb_top.sv ----
/*
 Self-checking bench for the converter sequencer: register port tasks,
 trigger pins, comparator model and output monitors.
 Assumes the package timing figures and a 50 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; \
   $display("[FAIL] t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_top;
   logic        clk;
   logic        reset_n;
   logic [3:0]  addr;
   logic [15:0] wdata;
   logic        wr;
   logic        rd;
   logic [15:0] rdata;
   logic        reload_out;
   logic        freerun_zero;
   logic        cmp_hi;
   logic [2:0]  ch_sel;
   logic        sample_hold;
   logic [9:0]  dac_code;
   logic        irq;
   logic        xfer_req;
   logic        busy;
   logic [9:0]  level [8];
   logic [15:0] exp_q [$];
   logic [2:0]  ch_q [$];
   logic [15:0] seed;
   logic [15:0] e;
   logic [2:0]  ch;
   logic        rd_q;
   logic        sh_q;
   int          s_len;
   int          b_len;
   int          err_total;
   int          tests_run;

   sar_adc_sequencer dut (.clk(clk), .reset_n(reset_n), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .reload_out(reload_out), .freerun_zero(freerun_zero),
      .cmp_hi(cmp_hi), .ch_sel(ch_sel), .sample_hold(sample_hold),
      .dac_code(dac_code), .irq(irq), .xfer_req(xfer_req), .busy(busy));
   adc_front_model front (.clk(clk), .ch_sel(ch_sel),
      .sample_hold(sample_hold), .dac_code(dac_code), .level(level),
      .cmp_hi(cmp_hi));

   // ==========================================================
   // Helpers
   function automatic logic [15:0] xs(input logic [15:0] x);
      x ^= x << 7;
      x ^= x >> 9;
      x ^= x << 8;
      return x;
   endfunction

   function automatic logic [15:0] cw(input logic [1:0] m, input logic [1:0] s,
                                      input logic r8, input logic sc,
                                      input logic xf);
      return {9'h000, xf, sc, r8, s, m};
   endfunction

   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask

   task automatic rd_chk(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      exp_q.push_back(d);
      @(posedge clk);
      rd   <= 1'b0;
   endtask

   task automatic wait_idle();
      int n;
      n = 0;
      repeat (8) @(posedge clk);
      while (busy !== 1'b0 && n < 20000)
      begin
         @(posedge clk);
         n++;
      end
      `CHK(busy, 1'b0)
   endtask

   task automatic chk_ch(input int n, input logic [2:0] first);
      logic [2:0] c;
      `CHK(ch_q.size(), n)
      for (int i = 0; i < n && ch_q.size() > 0; i++)
      begin
         c = ch_q.pop_front();
         `CHK(c, first + 3'(i))
      end
      ch_q.delete();
   endtask

   task automatic conv(input logic [15:0] c, input logic [15:0] r);
      wr_reg(adc_seq_pkg::OFF_CTRL, c);
      wr_reg(adc_seq_pkg::OFF_RANGE, r);
      wr_reg(adc_seq_pkg::OFF_CMD, 16'h0001);
      wait_idle();
   endtask

   task automatic wrap_up();
      $display("tests_run=%0d err_total=%0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // ==========================================================
   // Clock, monitors and watchdog
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   always @(posedge clk) rd_q <= rd;

   // Checks sit on the falling edge so every registered output has settled
   always @(negedge clk)
   begin
      if (rd_q === 1'b1)
      begin
         e = exp_q.pop_front();
         `CHK(rdata, e)
      end
      if (sample_hold === 1'b1 && sh_q !== 1'b1)
         ch_q.push_back(ch_sel);
      sh_q = sample_hold;
      if (sample_hold === 1'b1)
         s_len++;
      else if (s_len > 0)
      begin
         `CHK(s_len >= adc_seq_pkg::SAMPLE_CYC, 1'b1)
         s_len = 0;
      end
      if (busy === 1'b1)
         b_len++;
      else if (b_len > 0)
      begin
         `CHK(b_len >= adc_seq_pkg::CONV_CYC, 1'b1)
         b_len = 0;
      end
   end

   initial
   begin
      repeat (100000) @(posedge clk);
      err_total++;
      wrap_up();
   end

   // ==========================================================
   // Main sequence
   initial
   begin
      reset_n = 1'b0;
      {addr, wdata, wr, rd, reload_out, freerun_zero} = '0;
      {rd_q, sh_q, s_len, b_len, err_total, tests_run} = '0;
      seed = 16'd38607;
      for (int i = 0; i < 8; i++)
      begin
         seed = xs(seed);
         level[i] = seed[9:0];
      end
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      foreach (level[i])
         rd_chk(4'(i), 16'h0000);
      rd_chk(4'hf, 16'h0000);
      $display("test reset_values done");
      // Second start mid-conversion must be dropped
      for (int m = 0; m < 2; m++)
      begin
         seed = xs(seed);
         ch = seed[2:0];
         wr_reg(adc_seq_pkg::OFF_CTRL, cw(2'(m), 2'd0, 1'b0, 1'b0, 1'b0));
         wr_reg(adc_seq_pkg::OFF_RANGE, {13'h0, ch});
         wr_reg(adc_seq_pkg::OFF_CMD, 16'h0001);
         repeat (40) @(posedge clk);
         `CHK(busy, 1'b1)
         wr_reg(adc_seq_pkg::OFF_CMD, 16'h0001);
         wait_idle();
         chk_ch(1, ch);
         rd_chk(adc_seq_pkg::OFF_RESULT, {6'h00, level[ch]});
         rd_chk(adc_seq_pkg::OFF_STATUS, 16'h0000);
      end
      $display("test single done");
      level[0] = 10'h3a5;
      conv(cw(2'd0, 2'd0, 1'b1, 1'b0, 1'b0), 16'h0000);
      chk_ch(1, 3'd0);
      rd_chk(adc_seq_pkg::OFF_RESULT, 16'h00e9);
      conv(cw(2'd0, 2'd0, 1'b0, 1'b1, 1'b0), 16'h0031);
      chk_ch(3, 3'd1);
      rd_chk(adc_seq_pkg::OFF_RESULT, {6'h00, level[3]});
      $display("test res8_scan done");
      for (int sc = 0; sc < 2; sc++)
      begin
         wr_reg(adc_seq_pkg::OFF_CTRL, cw(2'd2, 2'd0, 1'b0, 1'(sc), 1'b0));
         wr_reg(adc_seq_pkg::OFF_RANGE, sc ? 16'h0076 : 16'h0004);
         wr_reg(adc_seq_pkg::OFF_CMD, 16'h0001);
         for (int n = 0; n < 3000 && ch_q.size() < 5; n++)
            @(posedge clk);
         // Stop well inside the step phase so no sample run is cut short
         repeat (150) @(posedge clk);
         `CHK(ch_q.size() >= 5, 1'b1)
         wr_reg(adc_seq_pkg::OFF_CMD, 16'h0080);
         wait_idle();
         foreach (ch_q[i])
            `CHK(ch_q[i], sc ? 3'(6 + i % 2) : 3'd4)
         ch_q.delete();
      end
      $display("test continuous done");
      wr_reg(adc_seq_pkg::OFF_CTRL, cw(2'd3, 2'd0, 1'b0, 1'b1, 1'b0));
      wr_reg(adc_seq_pkg::OFF_RANGE, 16'h0032);
      for (int k = 0; k < 2; k++)
      begin
         wr_reg(adc_seq_pkg::OFF_CMD, 16'h0001);
         wait_idle();
         repeat (50) @(posedge clk);
         chk_ch(1, 3'(2 + k));
         rd_chk(adc_seq_pkg::OFF_STATUS, k ? 16'h0004 : 16'h0006);
         rd_chk(adc_seq_pkg::OFF_RESULT, {6'h00, level[2 + k]});
      end
      wr_reg(adc_seq_pkg::OFF_CMD, 16'h0080);
      $display("test incremental done");
      for (int s = 1; s < 3; s++)
      begin
         wr_reg(adc_seq_pkg::OFF_CTRL, cw(2'd0, 2'(s), 1'b0, 1'b0, 1'b0));
         wr_reg(adc_seq_pkg::OFF_RANGE, 16'h0005);
         @(posedge clk);
         reload_out   <= (s == 1);
         freerun_zero <= (s == 2);
         repeat (3) @(posedge clk);
         {reload_out, freerun_zero} <= 2'b00;
         wait_idle();
         chk_ch(1, 3'd5);
      end
      reload_out <= 1'b1;
      repeat (20) @(posedge clk);
      reload_out <= 1'b0;
      `CHK(busy, 1'b0)
      rd_chk(adc_seq_pkg::OFF_RESULT, {6'h00, level[5]});
      $display("test sources done");
      wr_reg(adc_seq_pkg::OFF_IRQ_ST, 16'h0003);
      wr_reg(adc_seq_pkg::OFF_IRQ_MK, 16'h0001);
      conv(cw(2'd0, 2'd0, 1'b0, 1'b0, 1'b0), 16'h0000);
      conv(cw(2'd0, 2'd0, 1'b0, 1'b0, 1'b0), 16'h0001);
      repeat (3) @(posedge clk);
      `CHK(irq, 1'b1)
      rd_chk(adc_seq_pkg::OFF_IRQ_ST, 16'h0003);
      wr_reg(adc_seq_pkg::OFF_CTRL, cw(2'd0, 2'd0, 1'b0, 1'b0, 1'b1));
      repeat (3) @(posedge clk);
      `CHK({xfer_req, irq}, 2'b10)
      rd_chk(adc_seq_pkg::OFF_RESULT, 16'h03a5);
      wr_reg(adc_seq_pkg::OFF_IRQ_ST, 16'h0003);
      wr_reg(adc_seq_pkg::OFF_IRQ_MK, 16'h0000);
      conv(cw(2'd0, 2'd0, 1'b0, 1'b0, 1'b0), 16'h0001);
      repeat (3) @(posedge clk);
      `CHK({xfer_req, irq}, 2'b00)
      rd_chk(adc_seq_pkg::OFF_IRQ_ST, 16'h0001);
      wr_reg(adc_seq_pkg::OFF_IRQ_MK, 16'h0001);
      repeat (3) @(posedge clk);
      `CHK(irq, 1'b1)
      wr_reg(adc_seq_pkg::OFF_IRQ_ST, 16'h0001);
      repeat (3) @(posedge clk);
      `CHK(irq, 1'b0)
      ch_q.delete();
      $display("test irq_protect done");
      repeat (4) @(posedge clk);
      wrap_up();
   end
endmodule // tb_top
`default_nettype wire
